//--- logic/aps_sequencer.sv
// Purpose: Power-up, soft shutdown, channel enables, short recovery.
// Assumes: Register port driven by I2C logic on clock_i.
// Notes:   Pin and analog sense inputs pass two flops first.
`timescale 1ns/1ps
`include "aps_regs.svh"

module aps_sequencer #(
  parameter int STARTUP_CYCLES = `APS_STARTUP_CYC
) (
  input wire logic clock_i,              // Core clock, 25 MHz
  input wire logic sys_rst_i,            // Async reset, high
  input wire logic shutdown_pin_n_i,     // Shutdown pin, low = off
  input aps_pkg::aps_reg_req_t reg_req_i, // Register write request
  output logic [7:0] reg_rdata_o,        // Read data, one cycle late
  input wire logic short_detect_i,       // Output short sense
  input wire logic above_gate_i,         // Input above noise gate
  input wire logic agc_on_i,             // Gain control active
  input wire logic [4:0] fixed_gain_i,   // Fixed gain setting, dB
  input wire logic [23:0] attack_cyc_i,  // Attack interval, cycles
  input wire logic [23:0] release_cyc_i, // Release interval, cycles
  output logic out_stage_en_o,           // Class-D stage enable
  output logic left_channel_on_o,        // Left speaker amp on
  output logic right_channel_on_o,       // Right speaker amp on
  output logic [4:0] gain_o,             // Applied gain, dB
  output logic fault_o,                  // Sticky short fault
  output logic ready_o                   // Fully operational
);

  localparam logic [19:0] START_LAST = 20'(STARTUP_CYCLES - 1);
  localparam logic [19:0] RETRY_LAST = 20'(`APS_RETRY_CYC - 1);
  localparam logic [19:0] TRY_LAST = 20'(`APS_TRY_CYC - 1);

  aps_pkg::aps_seq_st_t s;
  aps_pkg::aps_seq_st_t n;

  logic pin_up;
  logic shorted;
  logic above;
  logic wr_ctrl;
  logic short_evt;
  logic ramp_load;
  logic [4:0] ramp_val;
  logic ramp_hold;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // Only sync_b is read; sync_a feeds nothing else
    n.sync_a = {shutdown_pin_n_i, short_detect_i, above_gate_i};
    n.sync_b = s.sync_a;
    pin_up = s.sync_b[2];
    shorted = s.sync_b[1];
    above = s.sync_b[0];
    short_evt = 1'b0;

    wr_ctrl = reg_req_i.wr && (reg_req_i.addr == `APS_CTRL_ADDR);
    n.rdata = (reg_req_i.addr == `APS_CTRL_ADDR) ? s.ctrl : 8'h00;

    // Writes keep every other bit; fault is write-one-to-clear
    if (wr_ctrl) begin
      n.ctrl = (s.ctrl & ~`APS_CTRL_WMASK) |
               (reg_req_i.wdata & `APS_CTRL_WMASK);
      if (reg_req_i.wdata[`APS_FAULT_BIT]) begin
        n.ctrl[`APS_FAULT_BIT] = 1'b0;
      end
    end

    case (s.state)
      aps_pkg::APS_OFF: begin
        if (pin_up) begin
          n.state = aps_pkg::APS_START;
          n.cnt = 20'h0;
        end
      end
      aps_pkg::APS_START: begin
        n.cnt = s.cnt + 20'h1;
        if (s.cnt == START_LAST) begin
          n.state = aps_pkg::APS_RUN;
          n.cnt = 20'h0;
        end
      end
      aps_pkg::APS_RUN: begin
        if (shorted) begin
          short_evt = 1'b1;
          n.state = aps_pkg::APS_SC_OFF;
          n.cnt = 20'h0;
        end
      end
      aps_pkg::APS_SC_OFF: begin
        n.cnt = s.cnt + 20'h1;
        if (s.cnt == RETRY_LAST) begin
          n.state = aps_pkg::APS_SC_TRY;
          n.cnt = 20'h0;
        end
      end
      aps_pkg::APS_SC_TRY: begin
        n.cnt = s.cnt + 20'h1;
        if (shorted) begin
          short_evt = 1'b1;
          n.state = aps_pkg::APS_SC_OFF;
          n.cnt = 20'h0;
        end else if (s.cnt == TRY_LAST) begin
          n.state = aps_pkg::APS_RUN;
          n.cnt = 20'h0;
        end
      end
      default: begin
        n.state = aps_pkg::APS_OFF;
        n.cnt = 20'h0;
      end
    endcase

    // Set after the write clear so a short wins over a same-cycle clear write
    if (short_evt) begin
      n.ctrl[`APS_FAULT_BIT] = 1'b1;
    end

    if (s.state == aps_pkg::APS_RUN && above) begin
      n.gate_seen = 1'b1;
    end

    // Pin low acts like a reset of everything but the synchronisers
    if (!pin_up) begin
      n.state = aps_pkg::APS_OFF;
      n.cnt = 20'h0;
      n.ctrl = `APS_CTRL_RESET;
      n.rdata = 8'h00;
      n.gate_seen = 1'b0;
    end

    // Retry window drives the stage briefly: low duty while shorted
    n.out_en = (n.state == aps_pkg::APS_RUN ||
                n.state == aps_pkg::APS_SC_TRY) &&
               !n.ctrl[`APS_SWS_BIT];
    n.left_on = n.out_en && n.ctrl[`APS_LEFT_BIT];
    n.right_on = n.out_en && n.ctrl[`APS_RIGHT_BIT];
    n.ready = n.out_en && (n.state == aps_pkg::APS_RUN);
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Gain start-up choice
  // ----------------------------------------------------------------
  // Loading every cycle while idle means the gain is already right
  // at the moment audio starts; no pacing is paid at release.
  always_comb begin
    ramp_load = 1'b1;
    ramp_val = fixed_gain_i;
    ramp_hold = !(s.gate_seen && above);
    if (s.state == aps_pkg::APS_OFF ||
        s.state == aps_pkg::APS_START) begin
      ramp_val = `APS_DEFAULT_GAIN;
    end else if (s.ctrl[`APS_SWS_BIT]) begin
      ramp_val = fixed_gain_i;
    end else if (!s.ctrl[`APS_LEFT_BIT] &&
                 !s.ctrl[`APS_RIGHT_BIT]) begin
      ramp_val = fixed_gain_i;
    end else if (!agc_on_i) begin
      ramp_val = fixed_gain_i;
    end else begin
      ramp_load = 1'b0;
    end
  end

  aps_gain_ramp u_ramp (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .load_i(ramp_load),
    .load_val_i(ramp_val),
    .hold_i(ramp_hold),
    .target_i(fixed_gain_i),
    .attack_cyc_i(attack_cyc_i),
    .release_cyc_i(release_cyc_i),
    .gain_o(gain_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = s.rdata;
  assign out_stage_en_o = s.out_en;
  assign left_channel_on_o = s.left_on;
  assign right_channel_on_o = s.right_on;
  assign fault_o = s.ctrl[`APS_FAULT_BIT];
  assign ready_o = s.ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SHORT_OFF: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_RUN && s.sync_b[1] && s.sync_b[2])
      |=> !s.out_en ##0 s.state == aps_pkg::APS_SC_OFF)
    else $error("short did not drop the output stage");

  AST_RETRY_TIME: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_SC_OFF && s.cnt == RETRY_LAST &&
     s.sync_b[2]) |=> s.state == aps_pkg::APS_SC_TRY)
    else $error("retry not taken at the interval");

  // A pin drop during the off span legally ends the attempt
  AST_RETRY_AGAIN: assert property (
    @(posedge clock_i) disable iff (sys_rst_i || !s.sync_b[2])
    (s.state == aps_pkg::APS_SC_TRY && s.sync_b[1] && s.sync_b[2])
      |=> s.state == aps_pkg::APS_SC_OFF ##1
      s.state == aps_pkg::APS_SC_OFF [*8])
    else $error("persisting short not retried");

  AST_RECOVER: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_SC_TRY && s.cnt == TRY_LAST &&
     !s.sync_b[1] && s.sync_b[2])
      |=> s.state == aps_pkg::APS_RUN)
    else $error("no recovery after short cleared");

  AST_FAULT_STICKY: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.ctrl[`APS_FAULT_BIT] && s.sync_b[2] &&
     !(reg_req_i.wr && reg_req_i.addr == `APS_CTRL_ADDR &&
       reg_req_i.wdata[`APS_FAULT_BIT]))
      |=> s.ctrl[`APS_FAULT_BIT])
    else $error("fault cleared without a write");

  AST_FAULT_SET: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_RUN && s.sync_b[1] && s.sync_b[2])
      |=> fault_o)
    else $error("short did not set fault");

  AST_STARTUP_QUIET: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_START) |-> !s.out_en && !s.ready)
    else $error("output stage on during start-up");

  AST_STARTUP_DONE: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_START && s.cnt == START_LAST &&
     s.sync_b[2]) |=> s.state == aps_pkg::APS_RUN)
    else $error("start-up did not finish on time");

  AST_PIN_LOW: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !s.sync_b[2] |=> s.ctrl == `APS_CTRL_RESET && !s.out_en &&
      s.state == aps_pkg::APS_OFF)
    else $error("pin low did not reset the block");

  AST_SOFT_OFF: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    s.ctrl[`APS_SWS_BIT] |-> !s.out_en && !s.left_on && !s.right_on)
    else $error("soft shutdown left output on");

  AST_CHANNEL: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.left_on == (s.out_en && s.ctrl[`APS_LEFT_BIT])) &&
    (s.right_on == (s.out_en && s.ctrl[`APS_RIGHT_BIT])))
    else $error("channel enable mismatch");

  AST_SOFT_RELEASE: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ($fell(s.ctrl[`APS_SWS_BIT]) && $past(s.state) == aps_pkg::APS_RUN)
      |-> gain_o == $past(fixed_gain_i))
    else $error("soft release not at latest gain");

  AST_HW_GAIN: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (s.state == aps_pkg::APS_START) |=> gain_o == `APS_DEFAULT_GAIN)
    else $error("hardware start not at default gain");

endmodule : aps_sequencer

//--- pkg/aps_regs.svh
// Purpose: Register map and timing constants of the amp sequencer.
// Assumes: 25 MHz core clock; register port from the I2C slave logic.
// Notes:   Shared by the package user files through `include.
// Functional notes
// - Short: output off, retry every 110 us
// - Retries endless; normal run once short clears
// - Fault bit 3 sticky until host write
// - Shutdown pin high powers control logic up
// - Soft shutdown clear after pin power-up
// - Output stage enabled 5 ms after pin rise
// - Hardware start begins at default fixed gain
// - Gain held until input first passes gate
// - Soft shutdown release starts at latest gain
// - Playback gain changes stepped at set rate; with agc_on_i low the gain loads at once
// - Both channels off: gain held at fixed
// - Defaults allow playback without any writes
// - Channel bits 6, 7 gate speakers only
// - Soft shutdown bit 5 disables, keeps registers
// - Pin low: all off, registers defaulted
// - Gain increases spaced by release interval
// - Gain frozen while input below noise gate
`ifndef APS_REGS_SVH
`define APS_REGS_SVH

`define APS_CTRL_ADDR 8'h01
`define APS_LEFT_BIT 7
`define APS_RIGHT_BIT 6
`define APS_SWS_BIT 5
`define APS_FAULT_BIT 3
`define APS_CTRL_RESET 8'hc0
`define APS_CTRL_WMASK 8'he0
`define APS_DEFAULT_GAIN 5'h06
`define APS_GAIN_MAX 5'h1e

`define APS_CLK_KHZ 25000
`define APS_STARTUP_MS 5
`define APS_STARTUP_CYC (`APS_STARTUP_MS * `APS_CLK_KHZ)
`define APS_RETRY_US 110
`define APS_RETRY_CYC (`APS_RETRY_US * `APS_CLK_KHZ / 1000)
`define APS_TRY_CYC 16

`endif

//--- pkg/aps_pkg.sv
// Purpose: Types of the amp power and fault sequencer.
// Assumes: Constants live in aps_regs.svh.
// Notes:   Nothing here is imported; users write aps_pkg::name.
package aps_pkg;

  typedef enum logic [2:0] {
    APS_OFF,
    APS_START,
    APS_RUN,
    APS_SC_OFF,
    APS_SC_TRY
  } aps_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aps_reg_req_t;

  typedef struct packed {
    logic [4:0] gain;
    logic [23:0] since;
  } aps_ramp_st_t;

  typedef struct packed {
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    aps_state_t state;
    logic [19:0] cnt;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic gate_seen;
    logic out_en;
    logic left_on;
    logic right_on;
    logic ready;
  } aps_seq_st_t;

endpackage : aps_pkg

//--- logic/aps_gain_ramp.sv
// Purpose: Gain stepper, 1 dB per step, paced by attack and release.
// Assumes: Interval inputs are in clock cycles.
// Notes:   Load wins over hold; hold freezes stepping only.
`timescale 1ns/1ps
`include "aps_regs.svh"

module aps_gain_ramp (
  input wire logic clock_i,            // Core clock
  input wire logic sys_rst_i,          // Async reset, high
  input wire logic load_i,             // Jump to load value now
  input wire logic [4:0] load_val_i,   // Gain taken on load
  input wire logic hold_i,             // Freeze stepping
  input wire logic [4:0] target_i,     // Gain to step toward
  input wire logic [23:0] attack_cyc_i,  // Least cycles between drops
  input wire logic [23:0] release_cyc_i, // Least cycles between rises
  output logic [4:0] gain_o            // Current gain, dB
);

  aps_pkg::aps_ramp_st_t s;
  aps_pkg::aps_ramp_st_t n;
  logic [4:0] tgt;
  logic rise_ok;
  logic fall_ok;

  // ----------------------------------------------------------------
  // Step logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    tgt = (target_i > `APS_GAIN_MAX) ? `APS_GAIN_MAX : target_i;
    rise_ok = ({1'b0, s.since} + 25'h1) >= {1'b0, release_cyc_i};
    fall_ok = ({1'b0, s.since} + 25'h1) >= {1'b0, attack_cyc_i};
    if (s.since != 24'hffffff) begin
      n.since = s.since + 24'h1;
    end
    if (load_i) begin
      n.gain = load_val_i;
      n.since = 24'h0;
    end else if (!hold_i) begin
      if (tgt > s.gain && rise_ok) begin
        n.gain = s.gain + 5'h1;
        n.since = 24'h0;
      end else if (tgt < s.gain && fall_ok) begin
        n.gain = s.gain - 5'h1;
        n.since = 24'h0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign gain_o = s.gain;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RISE_SPACING: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (!$past(load_i) && s.gain > $past(s.gain)) |->
      ({1'b0, $past(s.since)} + 25'h1) >= {1'b0, $past(release_cyc_i)})
    else $error("gain rose before release interval");

  AST_GATE_FREEZE: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (hold_i && !load_i) |=> $stable(s.gain))
    else $error("gain moved while held");

  AST_ONE_STEP: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !load_i |=> (s.gain == $past(s.gain) ||
      s.gain == $past(s.gain) + 5'h1 || s.gain == $past(s.gain) - 5'h1))
    else $error("gain jumped more than one step");

endmodule : aps_gain_ramp

//--- testbench/aps_host_model.sv
// Purpose: Host side of the sequencer: shutdown pin and register port.
// Assumes: Drives at the falling edge; block samples on the rising one.
// Notes:   Released write data is inverted so no stale byte lingers.
`timescale 1ns/1ps

module aps_host_model (
  input wire logic clock_i,                // Core clock
  input wire logic [7:0] reg_rdata_i,      // Read data from block
  output logic shutdown_pin_n_o,           // Shutdown pin, low = off
  output aps_pkg::aps_reg_req_t reg_req_o  // Register request
);
  initial begin
    shutdown_pin_n_o = 1'b0;
    reg_req_o = {1'b0, 8'h01, 8'h00};
  end

  // ----------------------------------------------------------------
  // Host operations
  // ----------------------------------------------------------------
  // The bench waits for each sequence to finish before the next call
  task automatic set_pin(input logic level);
    @(negedge clock_i);
    shutdown_pin_n_o = level;
  endtask : set_pin

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock_i);
    reg_req_o.addr = addr;
    reg_req_o.wdata = data;
    reg_req_o.wr = 1'b1;
    @(negedge clock_i);
    reg_req_o.wr = 1'b0;
    reg_req_o.wdata = ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock_i);
    reg_req_o.addr = addr;
    @(negedge clock_i);
    data = reg_rdata_i;
  endtask : read_reg
endmodule : aps_host_model

//--- testbench/aps_sequencer_tb.sv
// Purpose: Self-checking bench of the amp power and fault sequencer.
// Assumes: Start-up count shortened to 20 cycles; retry count kept.
// Notes:   Short recovery runs three retry periods, about 8k cycles.
`timescale 1ns/1ps
`include "aps_regs.svh"

module aps_sequencer_tb;
  localparam int STARTUP = 20;
  logic clock_i, sys_rst_i, short_detect_i, above_gate_i, agc_on_i;
  logic [4:0] fixed_gain_i, gain;
  logic [23:0] attack_cyc_i, release_cyc_i;
  logic shutdown_pin_n, out_en, left_on, right_on, fault, ready;
  aps_pkg::aps_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  int failures, checks;

  aps_sequencer #(.STARTUP_CYCLES(STARTUP)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .shutdown_pin_n_i(shutdown_pin_n), .reg_req_i(reg_req),
    .reg_rdata_o(reg_rdata), .short_detect_i(short_detect_i),
    .above_gate_i(above_gate_i), .agc_on_i(agc_on_i),
    .fixed_gain_i(fixed_gain_i), .attack_cyc_i(attack_cyc_i),
    .release_cyc_i(release_cyc_i), .out_stage_en_o(out_en),
    .left_channel_on_o(left_on), .right_channel_on_o(right_on),
    .gain_o(gain), .fault_o(fault), .ready_o(ready)
  );

  aps_host_model host (
    .clock_i(clock_i), .reg_rdata_i(reg_rdata),
    .shutdown_pin_n_o(shutdown_pin_n), .reg_req_o(reg_req)
  );

  always #20 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // Compare and wait helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    check_val("register", {8'h00, exp}, {8'h00, d});
  endtask : expect_reg

  // Waits for out_stage_en (sel 0) or ready (sel 1) to reach a level
  task automatic wait_level(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? out_en : ready) !== lvl && n < lim) begin
      @(negedge clock_i);
      n++;
    end
    if ((sel == 0 ? out_en : ready) !== lvl) begin
      failures++;
      $display("unexpected wait %0d: expected %b seen %b", sel, lvl,
               (sel == 0 ? out_en : ready));
      tally_and_finish();
    end
  endtask : wait_level

  // Counts falling-edge samples with the output stage off
  task automatic off_span(output int n);
    n = 0;
    while (out_en === 1'b0 && n < 3000) begin
      n++;
      @(negedge clock_i);
    end
  endtask : off_span

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scn_power_up;
    host.set_pin(1'b1);
    repeat (STARTUP - 4) @(negedge clock_i);
    check_bit("early stage", 1'b0, out_en);
    check_val("start gain", 16'(`APS_DEFAULT_GAIN), {11'h000, gain});
    wait_level(1, 1'b1, 12);
    check_bit("stage on", 1'b1, out_en);
    check_bit("left", 1'b1, left_on);
    check_bit("right", 1'b1, right_on);
    expect_reg(8'h01, `APS_CTRL_RESET);
  endtask : scn_power_up

  task automatic scn_gain_ramp;
    int n, since;
    logic [4:0] last;
    repeat (10) @(negedge clock_i);
    check_val("gated gain", 16'h0006, {11'h000, gain});
    above_gate_i = 1'b1;
    last = gain;
    since = 0;
    for (n = 0; n < 80 && gain !== 5'h0a; n++) begin
      @(negedge clock_i);
      since++;
      if (gain !== last) begin
        check_val("step", {11'h000, last + 5'h01}, {11'h000, gain});
        if (last != 5'h06) check_bit("spacing", 1'b1, since >= 4);
        last = gain;
        since = 0;
      end
    end
    check_val("ramp end", 16'h000a, {11'h000, gain});
    above_gate_i = 1'b0;
    // Gate must clear its synchroniser before the target moves
    repeat (4) @(negedge clock_i);
    fixed_gain_i = 5'h08;
    repeat (20) @(negedge clock_i);
    check_val("frozen", 16'h000a, {11'h000, gain});
    above_gate_i = 1'b1;
    repeat (20) @(negedge clock_i);
    check_val("attack end", 16'h0008, {11'h000, gain});
    agc_on_i = 1'b0;
    fixed_gain_i = 5'h10;
    repeat (2) @(negedge clock_i);
    check_val("agc off gain", 16'h0010, {11'h000, gain});
    agc_on_i = 1'b1;
  endtask : scn_gain_ramp

  task automatic scn_channels;
    host.write_reg(8'h01, 8'h80);
    expect_reg(8'h01, 8'h80);
    check_bit("left only", 1'b1, left_on);
    check_bit("right off", 1'b0, right_on);
    check_bit("still ready", 1'b1, ready);
    fixed_gain_i = 5'h0c;
    host.write_reg(8'h01, 8'h00);
    repeat (2) @(negedge clock_i);
    check_val("idle gain", 16'h000c, {11'h000, gain});
    host.write_reg(8'h01, 8'hc0);
    @(negedge clock_i);
    check_val("restart gain", 16'h000c, {11'h000, gain});
    check_bit("right back", 1'b1, right_on);
    host.write_reg(8'h02, 8'h00);
    expect_reg(8'h01, 8'hc0);
    expect_reg(8'h02, 8'h00);
  endtask : scn_channels

  task automatic scn_soft_shutdown;
    host.write_reg(8'h01, 8'he0);
    expect_reg(8'h01, 8'he0);
    check_bit("stage off", 1'b0, out_en);
    check_bit("left off", 1'b0, left_on);
    fixed_gain_i = 5'h03;
    repeat (3) @(negedge clock_i);
    host.write_reg(8'h01, 8'hc0);
    check_val("resume gain", 16'h0003, {11'h000, gain});
    wait_level(0, 1'b1, 4);
  endtask : scn_soft_shutdown

  task automatic scn_short;
    int n;
    short_detect_i = 1'b1;
    wait_level(0, 1'b0, 6);
    check_bit("fault set", 1'b1, fault);
    off_span(n);
    check_val("retry gap", 16'(`APS_RETRY_CYC), 16'(n));
    wait_level(0, 1'b0, 20);
    off_span(n);
    check_val("second gap", 16'(`APS_RETRY_CYC), 16'(n));
    short_detect_i = 1'b0;
    wait_level(1, 1'b1, 3000);
    check_bit("fault kept", 1'b1, fault);
    host.write_reg(8'h01, 8'hc0);
    expect_reg(8'h01, 8'hc8);
    host.write_reg(8'h01, 8'hc8);
    expect_reg(8'h01, 8'hc0);
    check_bit("fault clear", 1'b0, fault);
  endtask : scn_short

  task automatic scn_pin_low;
    host.write_reg(8'h01, 8'h48);
    check_bit("right before pin", 1'b1, right_on);
    host.set_pin(1'b0);
    repeat (4) @(negedge clock_i);
    check_bit("pin off stage", 1'b0, out_en);
    check_bit("pin off ready", 1'b0, ready);
    check_bit("pin off right", 1'b0, right_on);
    check_val("pin off gain", 16'h0006, {11'h000, gain});
    host.set_pin(1'b1);
    wait_level(1, 1'b1, STARTUP + 12);
    // Register port is dark while the pin is low; read once back up
    expect_reg(8'h01, `APS_CTRL_RESET);
  endtask : scn_pin_low

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    sys_rst_i = 1'b1;
    short_detect_i = 1'b0;
    above_gate_i = 1'b0;
    agc_on_i = 1'b1;
    fixed_gain_i = 5'h0a;
    attack_cyc_i = 24'h000002;
    release_cyc_i = 24'h000004;
    failures = 0;
    checks = 0;
    repeat (5) @(negedge clock_i);
    sys_rst_i = 1'b0;
    scn_power_up();
    scn_gain_ramp();
    scn_channels();
    scn_soft_shutdown();
    scn_short();
    scn_pin_low();
    tally_and_finish();
  end
endmodule : aps_sequencer_tb
